// [adpcr_map.vh]
// Purpose: register offsets, field positions and reset values
// Assumes: 8-bit register file reached on a byte address port
// Notes: definitions only
`ifndef ADPCR_MAP_VH
`define ADPCR_MAP_VH
`define ADPCR_OFS_POST_FILTER 8'h6C
`define ADPCR_OFS_AUTO_LEVEL 8'h70
`define ADPCR_OFS_INPUT_LANES 8'h73
`define ADPCR_OFS_OUTPUT_SLOTS 8'h74
`define ADPCR_OFS_POWER_UP 8'h75
`define ADPCR_OFS_LANE_STATUS 8'h76
`define ADPCR_RST_POST_FILTER 8'h40
`define ADPCR_RST_AUTO_LEVEL 8'hE7
`define ADPCR_RST_INPUT_LANES 8'hF0
`define ADPCR_RST_OUTPUT_SLOTS 8'h00
`define ADPCR_RST_POWER_UP 8'h00
`define ADPCR_BIT_GANG 7
`define ADPCR_BIQ_HI 6
`define ADPCR_BIQ_LO 5
`define ADPCR_BIT_NO_RAMP 4
`define ADPCR_BIT_GAIN_CONTROL_SELECT 3
`define ADPCR_LVL_HI 7
`define ADPCR_LVL_LO 4
`define ADPCR_MAXG_HI 3
`define ADPCR_MAXG_LO 0
`define ADPCR_BIT_BIAS 7
`define ADPCR_BIT_CONV 6
`define ADPCR_BIT_SYNTH 5
`define ADPCR_BIT_LIVE 4
`define ADPCR_SPAN_HI 3
`define ADPCR_SPAN_LO 2
`define ADPCR_MAXG_LAST 4'hD
`define ADPCR_PDM_MASK 8'h0F
`endif

// [adpcr_lane_power.v]
// Purpose: per-lane power state tracking
// Assumes: lane 1 at bit 7 down to lane 8 at bit 0
// Notes: changes while recording only when live switching is allowed or conversion is turned off
`timescale 1ns/1ps
`include "adpcr_map.vh"
module adpcr_lane_power #(
   parameter LANES = 8
) (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_ce,
   input wire i_conv_on,
   input wire i_live,
   input wire [1:0] i_span,
   input wire [LANES-1:0] i_enables,
   output wire [LANES-1:0] o_powered
);
   reg [LANES-1:0] pwr_r;
   reg [LANES-1:0] pwr_nxt;
   wire recording;
   assign recording = |pwr_r;
   // lanes covered by live switching: top 2, 4, 6 or 8 lanes
   function [LANES-1:0] span_mask;
      input [1:0] s;
      integer k;
      begin
         span_mask = {LANES{1'b0}};
         for (k = 0; k < LANES; k = k + 1) begin
            if ((LANES - 1 - k) < 2 * (s + 1))
               span_mask[k] = 1'b1;
         end
      end
   endfunction
   always @* begin
      if (!i_conv_on) begin
         pwr_nxt = {LANES{1'b0}};
      end else if (!recording) begin
         pwr_nxt = i_enables;
      end else if (i_live) begin
         // individual switching within the live span
         pwr_nxt = (i_enables & span_mask(i_span)) |
            (pwr_r & ~span_mask(i_span));
      end else begin
         pwr_nxt = pwr_r;
      end
   end
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pwr_r <= {LANES{1'b0}};
      end else if (i_ce) begin
         pwr_r <= pwr_nxt;
      end
   end
   assign o_powered = pwr_r;
endmodule // adpcr_lane_power

// [adpcr_config_regs.v]
// Purpose: audio converter volume, filter, gain control and power registers
// Assumes: byte register port synchronous to I_CLK_SYS
// Notes: outputs drive the datapath and analog power switches
`timescale 1ns/1ps
`include "adpcr_map.vh"
module adpcr_config_regs #(
   parameter LANES = 8,
   parameter VOL_W = 8
) (
   input wire I_CLK_SYS,
   input wire I_RST_N,
   input wire I_CE,
   input wire [7:0] I_ADDR,
   input wire I_WR,
   input wire [7:0] I_WDATA,
   output reg [7:0] O_RDATA,
   input wire [LANES*VOL_W-1:0] I_LANE_VOLUME,
   input wire [LANES-1:0] I_AGC_LANE_EN,
   output reg [LANES*VOL_W-1:0] O_APPLIED_VOLUME,
   output reg O_RAMP_EN,
   output reg [1:0] O_BIQUAD_COUNT,
   output reg [LANES-1:0] O_AGC_ACTIVE,
   output reg [3:0] O_AGC_TARGET,
   output reg [3:0] O_AGC_CEILING,
   output reg O_AGC_CEIL_RSVD,
   output reg [LANES-1:0] O_ANALOG_ON,
   output reg [LANES-1:0] O_PDM_ON,
   output reg [LANES-1:0] O_SLOT_OE,
   output reg O_MIC_BIAS_ON,
   output reg O_SYNTH_ON,
   output wire [LANES-1:0] O_LANE_POWERED
);
   reg [7:0] post_filter_options_r;
   reg [7:0] auto_level_config_r;
   reg [7:0] input_lane_enables_r;
   reg [7:0] output_slot_enables_r;
   reg [7:0] power_up_control_r;
   reg [LANES*VOL_W-1:0] vol_nxt;
   reg [LANES-1:0] agc_nxt;
   wire [LANES-1:0] powered;
   wire [LANES-1:0] pdm_mask;
   integer j;

   assign pdm_mask = `ADPCR_PDM_MASK;

   // address decode shared by write and read paths
   function hit;
      input [7:0] a;
      input [7:0] ofs;
      begin
         hit = (a == ofs);
      end
   endfunction

   always @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         post_filter_options_r <= `ADPCR_RST_POST_FILTER;
         auto_level_config_r <= `ADPCR_RST_AUTO_LEVEL;
         input_lane_enables_r <= `ADPCR_RST_INPUT_LANES;
         output_slot_enables_r <= `ADPCR_RST_OUTPUT_SLOTS;
         power_up_control_r <= `ADPCR_RST_POWER_UP;
      end else if (I_CE && I_WR) begin
         // reserved bits are kept as written
         if (hit(I_ADDR, `ADPCR_OFS_POST_FILTER))
            post_filter_options_r <= I_WDATA;
         if (hit(I_ADDR, `ADPCR_OFS_AUTO_LEVEL))
            auto_level_config_r <= I_WDATA;
         if (hit(I_ADDR, `ADPCR_OFS_INPUT_LANES))
            input_lane_enables_r <= I_WDATA;
         if (hit(I_ADDR, `ADPCR_OFS_OUTPUT_SLOTS))
            output_slot_enables_r <= I_WDATA;
         if (hit(I_ADDR, `ADPCR_OFS_POWER_UP))
            power_up_control_r <= I_WDATA;
      end
   end

   adpcr_lane_power #(
      .LANES(LANES)
   ) u_lane_power (
      .i_clk(I_CLK_SYS),
      .i_rst_n(I_RST_N),
      .i_ce(I_CE),
      .i_conv_on(power_up_control_r[`ADPCR_BIT_CONV]),
      .i_live(power_up_control_r[`ADPCR_BIT_LIVE]),
      .i_span(power_up_control_r[`ADPCR_SPAN_HI:`ADPCR_SPAN_LO]),
      .i_enables(input_lane_enables_r[LANES-1:0]),
      .o_powered(powered)
   );
   assign O_LANE_POWERED = powered;

   always @* begin
      vol_nxt = I_LANE_VOLUME;
      agc_nxt = {LANES{1'b0}};
      for (j = 0; j < LANES; j = j + 1) begin
         // lane 1 sits in the top slice, matching register bit order
         if (post_filter_options_r[`ADPCR_BIT_GANG])
            vol_nxt[j*VOL_W +: VOL_W] =
               I_LANE_VOLUME[(LANES-1)*VOL_W +: VOL_W];
         else
            vol_nxt[j*VOL_W +: VOL_W] =
               I_LANE_VOLUME[j*VOL_W +: VOL_W];
         agc_nxt[j] = I_AGC_LANE_EN[j] &
            post_filter_options_r[`ADPCR_BIT_GAIN_CONTROL_SELECT];
      end
   end

   always @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_APPLIED_VOLUME <= {LANES*VOL_W{1'b0}};
         O_RAMP_EN <= 1'b1;
         O_BIQUAD_COUNT <= 2'b10;
         O_AGC_ACTIVE <= {LANES{1'b0}};
         O_AGC_TARGET <= 4'hE;
         O_AGC_CEILING <= 4'h7;
         O_AGC_CEIL_RSVD <= 1'b0;
         O_ANALOG_ON <= {LANES{1'b0}};
         O_PDM_ON <= {LANES{1'b0}};
         O_SLOT_OE <= {LANES{1'b0}};
         O_MIC_BIAS_ON <= 1'b0;
         O_SYNTH_ON <= 1'b0;
         O_RDATA <= 8'h00;
      end else if (I_CE) begin
         O_APPLIED_VOLUME <= vol_nxt;
         O_RAMP_EN <= ~post_filter_options_r[`ADPCR_BIT_NO_RAMP];
         O_BIQUAD_COUNT <=
            post_filter_options_r[`ADPCR_BIQ_HI:`ADPCR_BIQ_LO];
         O_AGC_ACTIVE <= agc_nxt;
         O_AGC_TARGET <=
            auto_level_config_r[`ADPCR_LVL_HI:`ADPCR_LVL_LO];
         O_AGC_CEILING <=
            auto_level_config_r[`ADPCR_MAXG_HI:`ADPCR_MAXG_LO];
         O_AGC_CEIL_RSVD <=
            (auto_level_config_r[`ADPCR_MAXG_HI:`ADPCR_MAXG_LO] >
             `ADPCR_MAXG_LAST);
         // lanes 5..8 feed only the pulse density path
         O_ANALOG_ON <= powered & ~pdm_mask;
         O_PDM_ON <= powered;
         O_SLOT_OE <= output_slot_enables_r[LANES-1:0];
         O_MIC_BIAS_ON <= power_up_control_r[`ADPCR_BIT_BIAS];
         O_SYNTH_ON <= power_up_control_r[`ADPCR_BIT_SYNTH];
         if (hit(I_ADDR, `ADPCR_OFS_POST_FILTER))
            O_RDATA <= post_filter_options_r;
         else if (hit(I_ADDR, `ADPCR_OFS_AUTO_LEVEL))
            O_RDATA <= auto_level_config_r;
         else if (hit(I_ADDR, `ADPCR_OFS_INPUT_LANES))
            O_RDATA <= input_lane_enables_r;
         else if (hit(I_ADDR, `ADPCR_OFS_OUTPUT_SLOTS))
            O_RDATA <= output_slot_enables_r;
         else if (hit(I_ADDR, `ADPCR_OFS_POWER_UP))
            O_RDATA <= power_up_control_r;
         else if (hit(I_ADDR, `ADPCR_OFS_LANE_STATUS))
            O_RDATA <= powered;
         else
            O_RDATA <= 8'h00;
      end
   end
endmodule // adpcr_config_regs

// [adpcr_cfg_asserts.sv]
// Purpose: port checks of the config register block
// Assumes: derived outputs follow a register write by two edges
// Notes: bound into adpcr_config_regs
`timescale 1ns/1ps
module adpcr_cfg_asserts #(
   parameter LANES = 8
) (
   input wire I_CLK_SYS,
   input wire I_RST_N,
   input wire I_CE,
   input wire I_WR,
   input wire [7:0] I_ADDR,
   input wire [7:0] I_WDATA,
   input wire O_RAMP_EN,
   input wire [1:0] O_BIQUAD_COUNT,
   input wire [3:0] O_AGC_TARGET,
   input wire [3:0] O_AGC_CEILING,
   input wire O_AGC_CEIL_RSVD,
   input wire [LANES-1:0] O_ANALOG_ON,
   input wire [LANES-1:0] O_PDM_ON,
   input wire [LANES-1:0] O_SLOT_OE,
   input wire O_MIC_BIAS_ON,
   input wire O_SYNTH_ON,
   input wire [LANES-1:0] O_LANE_POWERED
);
   wire w6c = I_CE & I_WR & (I_ADDR == 8'h6C);
   wire w70 = I_CE & I_WR & (I_ADDR == 8'h70);
   wire w74 = I_CE & I_WR & (I_ADDR == 8'h74);
   wire w75 = I_CE & I_WR & (I_ADDR == 8'h75);
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RST_N);
   AST_DSP: assert property (w6c ##1 I_CE |=>
      {O_BIQUAD_COUNT, O_RAMP_EN} == ($past(I_WDATA[6:4], 2) ^ 3'h1))
      else $error("filter or ramp mismatch");
   AST_LEVEL: assert property (w70 ##1 I_CE |=>
      {O_AGC_TARGET, O_AGC_CEILING} == $past(I_WDATA, 2))
      else $error("gain field mismatch");
   AST_RSVD: assert property (
      O_AGC_CEIL_RSVD == (O_AGC_CEILING > 4'hD))
      else $error("reserved ceiling flag mismatch");
   AST_SLOT: assert property (w74 ##1 I_CE |=>
      O_SLOT_OE == $past(I_WDATA, 2)) else $error("slot enable mismatch");
   AST_BIAS: assert property (w75 ##1 I_CE |=>
      O_MIC_BIAS_ON == $past(I_WDATA[7], 2)) else $error("bias mismatch");
   AST_SYNTH: assert property (w75 ##1 I_CE |=>
      O_SYNTH_ON == $past(I_WDATA[5], 2)) else $error("synth mismatch");
   AST_OFF: assert property (w75 && !I_WDATA[6] ##1 I_CE |=>
      O_LANE_POWERED == 8'h00) else $error("lanes stay powered");
   AST_PDM: assert property (I_CE |=>
      O_PDM_ON == $past(O_LANE_POWERED) &&
      O_ANALOG_ON == ($past(O_LANE_POWERED) & 8'hF0))
      else $error("lane power outputs mismatch");
endmodule // adpcr_cfg_asserts
bind adpcr_config_regs adpcr_cfg_asserts #(.LANES(LANES)) u_chk (.*);

// [testbench.sv]
// Purpose: self-checking bench of the config register block
// Assumes: inputs change 1 ns after the rising edge
// Notes: random data from a fixed xorshift seed
`timescale 1ns/1ps
module testbench;
   reg clk = 0, rst_n = 0, ce = 1, wr = 0;
   reg [7:0] addr = 8'h00, wd = 8'h00, agc = 8'h00, d, g;
   reg [63:0] vol = 64'h0;
   reg [31:0] seed = 32'h623D_DAF5, r;
   integer fail_count = 0, checked = 0, i;
   wire [7:0] rdata, ana, pdm, oe, agca, pwr;
   wire [63:0] avol;
   wire ramp, rsvd, bias, syn;
   wire [1:0] biq;
   wire [3:0] tgt, ceil;
   always #2.5 clk = ~clk;
   adpcr_config_regs DUT (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_CE(ce),
      .I_ADDR(addr), .I_WR(wr), .I_WDATA(wd), .O_RDATA(rdata),
      .I_LANE_VOLUME(vol), .I_AGC_LANE_EN(agc), .O_APPLIED_VOLUME(avol),
      .O_RAMP_EN(ramp), .O_BIQUAD_COUNT(biq), .O_AGC_ACTIVE(agca),
      .O_AGC_TARGET(tgt), .O_AGC_CEILING(ceil), .O_AGC_CEIL_RSVD(rsvd),
      .O_ANALOG_ON(ana), .O_PDM_ON(pdm), .O_SLOT_OE(oe),
      .O_MIC_BIAS_ON(bias), .O_SYNTH_ON(syn), .O_LANE_POWERED(pwr));
   function [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed;
   endfunction
   function [63:0] vexp(input gang, input [63:0] v);
      vexp = gang ? {8{v[63:56]}} : v;
   endfunction
   task tick(input integer n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task chk(input [63:0] seen, input [63:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         fail_count = fail_count + 1;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task put(input [7:0] a, input [7:0] v);
      addr = a;
      wd = v;
      wr = 1;
      tick(1);
      wr = 0;
   endtask
   task get(input [7:0] a, input [7:0] e);
      addr = a;
      tick(1);
      chk(rdata, e);
   endtask
   task end_of_test;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #100000;
      fail_count = fail_count + 1;
      end_of_test;
   end
   initial begin
      tick(8);
      rst_n = 1;
      chk({biq, tgt, ceil, ramp}, {2'h2, 4'hE, 4'h7, 1'h1});
      chk({oe, bias, syn, pwr}, 18'h0_0000);
      get(8'h6C, 8'h40);
      get(8'h70, 8'hE7);
      get(8'h73, 8'hF0);
      get(8'h74, 8'h00);
      get(8'h75, 8'h00);
      get(8'h50, 8'h00);
      for (i = 0; i < 40; i = i + 1) begin
         r = rnd();
         vol = {r, rnd()};
         agc = r[15:8];
         d = r[31:24];
         put(8'h6C, d);
         r = rnd();
         g = (i < 3) ? {r[7:4], 4'hD + i[3:0]} : r[7:0];
         put(8'h70, g);
         put(8'h74, r[15:8]);
         tick(2);
         chk(avol, vexp(d[7], vol));
         chk({biq, ramp, agca}, {d[6:5], ~d[4], agc & {8{d[3]}}});
         chk({tgt, ceil, rsvd}, {g, g[3:0] > 4'hD});
         chk(oe, r[15:8]);
         get(8'h6C, d);
      end
      put(8'h75, 8'hA3);
      tick(2);
      chk({bias, syn, pwr}, {2'h3, 8'h00});
      get(8'h75, 8'hA3);
      put(8'h73, 8'hFF);
      put(8'h75, 8'h40);
      tick(3);
      chk({pwr, ana, pdm, bias, syn}, {24'hFF_F0FF, 2'h0});
      get(8'h76, 8'hFF);
      put(8'h73, 8'h0F);
      tick(3);
      chk(pwr, 8'hFF);
      put(8'h75, 8'h54);
      tick(3);
      chk(pwr, 8'h0F);
      put(8'h76, 8'hAA);
      get(8'h76, 8'h0F);
      put(8'h75, 8'h00);
      tick(3);
      chk({pwr, ana, pdm}, 24'h00_0000);
      end_of_test;
   end
endmodule // testbench
